//--- pkg/sls_pkg.sv
// Constants and types for the serial link supervisor
package sls_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATION = 8'h04;
  localparam logic [7:0] OFF_TIMEOUT = 8'h08;
  localparam logic [7:0] OFF_BITRATE = 8'h0C;
  localparam logic [7:0] OFF_DEFCW = 8'h10;
  localparam logic [7:0] OFF_CRCCNT = 8'h14;
  localparam logic [7:0] OFF_TMOCNT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_SPDREF = 8'h20;
  localparam logic [7:0] OFF_CTLWORD = 8'h24;
  localparam logic [7:0] OFF_SWORD0 = 8'h28;
  localparam logic [7:0] OFF_SWORD3 = 8'h34;
  localparam logic [7:0] OFF_HIDX = 8'h38;
  // Control register field positions
  localparam int CTRL_PERMIT = 0;
  localparam int CTRL_BCAST = 1;
  localparam int CTRL_PROTO = 2;
  localparam int CTRL_FMT = 5;
  localparam int CTRL_ACT = 8;
  localparam int CTRL_POL = 10;
  // Protocol codes
  localparam logic [2:0] PROTO_NONE = 3'h0;
  localparam logic [2:0] PROTO_TRIB = 3'h1;
  localparam logic [2:0] PROTO_MB_RTU = 3'h2;
  localparam logic [2:0] PROTO_MB_ASCII = 3'h3;
  localparam logic [2:0] PROTO_D2D = 3'h4;
  localparam logic [2:0] PROTO_GATEWAY = 3'h5;
  // Character format codes; 4 and above are 7-bit
  localparam logic [2:0] FMT_8N = 3'h1;
  localparam logic [2:0] FMT_7E = 3'h4;
  // Bit rate codes: 1.2, 2.4, 4.8, 9.6, 19.2, 38.4 kBaud
  localparam logic [2:0] BAUD_9K6 = 3'h3;
  localparam logic [2:0] BAUD_19K2 = 3'h4;
  localparam logic [2:0] BAUD_38K4 = 3'h5;
  // Loss actions
  localparam logic [1:0] ACT_WARN = 2'h1;
  localparam logic [1:0] ACT_TRIP = 2'h2;
  // Addresses
  localparam logic [7:0] TRIB_ADDR_MAX = 8'h0E;
  localparam logic [7:0] TRIB_BCAST = 8'h0F;
  localparam logic [7:0] MB_BCAST = 8'h00;
  // Counters
  localparam logic [13:0] CNT_MAX = 14'h270F;
  localparam logic [9:0] TMO_MAX = 10'h3E7;
  localparam logic [6:0] HIDX_MAX = 7'h63;
  // Timing
  localparam longint CLK_HZ = 40000000;
  localparam longint TMO_STEP_MS = 100;
  localparam int TICK_CYC = int'(CLK_HZ * TMO_STEP_MS / 1000);
  // Link parameter selectors
  localparam logic [2:0] SEL_REF_A = 3'h0;
  localparam logic [2:0] SEL_REF_B = 3'h1;
  localparam logic [2:0] SEL_CW_A = 3'h2;
  localparam logic [2:0] SEL_CW_B = 3'h3;
  localparam logic [2:0] SEL_HIDX = 3'h4;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic permit;
    logic bcast;
    logic [2:0] proto;
    logic [2:0] fmt;
    logic [1:0] act;
    logic pol;
    logic [2:0] baud;
    logic [7:0] station;
    logic [9:0] tmo;
    logic [15:0] dcw_a;
    logic [15:0] dcw_b;
    logic [13:0] crc_cnt;
    logic [13:0] tmo_cnt;
    logic healthy;
    logic backup;
    logic warn;
    logic trip;
    logic accept;
    logic wr_rej;
    logic conflict;
    logic [15:0] ref_a;
    logic [15:0] ref_b;
    logic [15:0] cw_a;
    logic [15:0] cw_b;
    logic [6:0] hidx_link;
    logic [6:0] hidx_kp;
    logic [21:0] tick;
    logic [9:0] tenths;
  } sls_state_s;
endpackage

//--- src/sls_top.sv
// Serial link supervisor with APB register access
// Function
// - Write permit 0 rejects link parameter writes; 1 accepts reads and writes.
// - Broadcasts discarded when broadcast accept is 0, processed when 1.
// - Tributary protocol: station 0..14, address 15 is broadcast.
// - MODBUS RTU/ASCII: station 1..255, address 0 is broadcast.
// - Protocol codes 0 none, 1 tributary, 2 RTU, 3 ASCII, 4 D2D, 5 gateway.
// - Drive-to-drive forces 19.2 kBaud; timeout handling unchanged.
// - No valid message within timeout marks link unhealthy; next valid heals.
// - Timeout 0 disables detection and excludes link; else 0.1 to 99.9 s.
// - Loss action on timeout: 0 none, 1 warning, 2 trip.
// - On timeout, policy 0 keeps control words, 1 loads defaults.
// - One 16-bit default per link control word, any value.
// - Read-only count 0..9999 of CRC-failed messages.
// - Read-only count 0..9999 of timeouts, only when timeout above 0.
// - Char formats 1..7: 8N, 8E, 8O, 7E, 7O, 7 parity 0, 7 parity 1.
// - 7-bit formats not allowed with RTU or tributary protocol.
// - Two link-only speed references, -100% to +100%, drive the reference.
// - Two 16-bit control words, bits routable to control flags.
// - 64 status flags as four 16-bit words, flag 16n in bit 0.
// - Failed link switches references to backup sources.
// - History playback: write sample index 0..99, then read data.
// - Separate history index per access source.
// - Half duplex up to 38.4 kBaud; reception ignored while transmitting.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module sls_top
  import sls_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link receiver events
  input wire logic rx_msg_valid,
  input wire logic [7:0] rx_addr,
  input wire logic rx_crc_err,
  input wire logic rx_write,
  input wire logic [2:0] rx_param_sel,
  input wire logic [15:0] rx_param_data,
  input wire logic tx_busy,
  // Drive status
  input wire logic [63:0] status_flags,
  // Link configuration out
  output logic [2:0] protocol_select,
  output logic [2:0] port_bit_rate,
  output logic [2:0] char_format_select,
  output logic format_conflict,
  // Link results
  output logic msg_accept,
  output logic write_reject,
  output logic link_healthy,
  output logic use_backup_source,
  output logic loss_warning,
  output logic loss_trip,
  output logic [15:0] link_speed_ref_a,
  output logic [15:0] link_speed_ref_b,
  output logic [15:0] link_control_word_a,
  output logic [15:0] link_control_word_b,
  output logic [6:0] hist_index_link,
  output logic [6:0] hist_index_keypad
);

  sls_state_s st_r;
  sls_state_s st_nxt;
  logic rx_ok;
  logic crc_ev;
  logic tick_end;
  logic tmo_evt;

  function automatic logic addr_acc(input logic [2:0] p, input logic [7:0] st,
                                    input logic [7:0] a, input logic b);
    case (p)
      PROTO_TRIB: addr_acc = (a == st && st <= TRIB_ADDR_MAX) || (a == TRIB_BCAST && b);
      PROTO_MB_RTU, PROTO_MB_ASCII:
        addr_acc = (a == st && st != MB_BCAST) || (a == MB_BCAST && b);
      PROTO_D2D, PROTO_GATEWAY: addr_acc = 1'b1;
      default: addr_acc = 1'b0;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= OFF_HIDX);
  endfunction

  // Reception is blind while the transmitter owns the wire
  assign rx_ok = rx_msg_valid && !tx_busy && !st_r.conflict &&
                 addr_acc(st_r.proto, st_r.station, rx_addr, st_r.bcast);
  assign crc_ev = rx_crc_err && !tx_busy;
  assign tick_end = st_r.tick == 22'(TICK_CYCLES - 1);
  assign tmo_evt = !rx_ok && st_r.healthy && st_r.tmo != 10'h000 && tick_end &&
                   (st_r.tenths + 10'h001) >= st_r.tmo;

  always_comb begin
    logic wr;
    logic [15:0] wl;
    logic [1:0] sw_idx;
    wr = 1'b0;
    wl = 16'h0000;
    sw_idx = 2'h0;
    st_nxt = st_r;
    st_nxt.accept = rx_ok;
    st_nxt.wr_rej = 1'b0;
    // APB: one wait state, then pready for one cycle
    st_nxt.pready = psel && penable && !st_r.pready;
    st_nxt.pslverr = psel && penable && !st_r.pready && !is_mapped(paddr);
    wr = psel && penable && st_r.pready && pwrite && is_mapped(paddr);
    if (psel && penable && !st_r.pready) begin
      if (paddr == OFF_CTRL) begin
        st_nxt.prdata = {21'h000000, st_r.pol, st_r.act, st_r.fmt, st_r.proto,
                         st_r.bcast, st_r.permit};
      end else if (paddr == OFF_STATION) begin
        st_nxt.prdata = {24'h000000, st_r.station};
      end else if (paddr == OFF_TIMEOUT) begin
        st_nxt.prdata = {22'h000000, st_r.tmo};
      end else if (paddr == OFF_BITRATE) begin
        st_nxt.prdata = {29'h00000000, st_r.baud};
      end else if (paddr == OFF_DEFCW) begin
        st_nxt.prdata = {st_r.dcw_b, st_r.dcw_a};
      end else if (paddr == OFF_CRCCNT) begin
        st_nxt.prdata = {18'h00000, st_r.crc_cnt};
      end else if (paddr == OFF_TMOCNT) begin
        st_nxt.prdata = {18'h00000, st_r.tmo_cnt};
      end else if (paddr == OFF_STATUS) begin
        st_nxt.prdata = {26'h0000000, st_r.conflict, st_r.trip, st_r.warn,
                         st_r.backup, st_r.healthy, st_r.accept};
      end else if (paddr == OFF_SPDREF) begin
        st_nxt.prdata = {st_r.ref_b, st_r.ref_a};
      end else if (paddr == OFF_CTLWORD) begin
        st_nxt.prdata = {st_r.cw_b, st_r.cw_a};
      end else if (paddr >= OFF_SWORD0 && paddr <= OFF_SWORD3) begin
        // Word 0 sits at 28h, so the low address bits are rotated by two
        sw_idx = paddr[3:2] + 2'h2;
        st_nxt.prdata = {16'h0000, status_flags[{sw_idx, 4'h0} +: 16]};
      end else if (paddr == OFF_HIDX) begin
        st_nxt.prdata = {25'h0000000, st_r.hidx_kp};
      end else begin
        st_nxt.prdata = 32'h00000000;
      end
    end
    if (wr) begin
      if (paddr == OFF_CTRL) begin
        st_nxt.permit = pwdata[CTRL_PERMIT];
        st_nxt.bcast = pwdata[CTRL_BCAST];
        st_nxt.proto = pwdata[CTRL_PROTO +: 3];
        if (pwdata[CTRL_FMT +: 3] != 3'h0) begin
          st_nxt.fmt = pwdata[CTRL_FMT +: 3];
        end
        st_nxt.act = pwdata[CTRL_ACT +: 2];
        st_nxt.pol = pwdata[CTRL_POL];
      end else if (paddr == OFF_STATION) begin
        st_nxt.station = pwdata[7:0];
      end else if (paddr == OFF_TIMEOUT) begin
        st_nxt.tmo = pwdata[9:0] > TMO_MAX ? TMO_MAX : pwdata[9:0];
      end else if (paddr == OFF_BITRATE) begin
        st_nxt.baud = pwdata[2:0] > BAUD_38K4 ? BAUD_38K4 : pwdata[2:0];
      end else if (paddr == OFF_DEFCW) begin
        st_nxt.dcw_a = pwdata[15:0];
        st_nxt.dcw_b = pwdata[31:16];
      end else if (paddr == OFF_HIDX && pwdata[6:0] <= HIDX_MAX) begin
        st_nxt.hidx_kp = pwdata[6:0];
      end
    end
    if (st_nxt.proto == PROTO_D2D) begin
      st_nxt.baud = BAUD_19K2;
    end
    // 7-bit characters cannot carry RTU or tributary frames
    st_nxt.conflict = st_nxt.fmt >= FMT_7E &&
                      (st_nxt.proto == PROTO_MB_RTU || st_nxt.proto == PROTO_TRIB);
    if (crc_ev && st_r.crc_cnt != CNT_MAX) begin
      st_nxt.crc_cnt = st_r.crc_cnt + 14'h0001;
    end
    if (rx_ok) begin
      st_nxt.tick = 22'h000000;
      st_nxt.tenths = 10'h000;
      st_nxt.healthy = 1'b1;
      st_nxt.warn = 1'b0;
      st_nxt.trip = 1'b0;
      if (rx_write && !st_r.permit) begin
        st_nxt.wr_rej = 1'b1;
      end else if (rx_write) begin
        wl = rx_param_data;
        case (rx_param_sel)
          SEL_REF_A: st_nxt.ref_a = wl;
          SEL_REF_B: st_nxt.ref_b = wl;
          SEL_CW_A: st_nxt.cw_a = wl;
          SEL_CW_B: st_nxt.cw_b = wl;
          SEL_HIDX: begin
            if (wl <= 16'(HIDX_MAX)) begin
              st_nxt.hidx_link = wl[6:0];
            end
          end
          default: st_nxt.wr_rej = 1'b1;
        endcase
      end
    end else if (tmo_evt) begin
      st_nxt.tick = 22'h000000;
      st_nxt.tenths = 10'h000;
      st_nxt.healthy = 1'b0;
      if (st_r.tmo_cnt != CNT_MAX) begin
        st_nxt.tmo_cnt = st_r.tmo_cnt + 14'h0001;
      end
      st_nxt.warn = st_r.act == ACT_WARN;
      st_nxt.trip = st_r.act == ACT_TRIP;
      if (st_r.pol) begin
        st_nxt.cw_a = st_r.dcw_a;
        st_nxt.cw_b = st_r.dcw_b;
      end
    end else if (st_r.healthy && st_r.tmo != 10'h000) begin
      if (tick_end) begin
        st_nxt.tick = 22'h000000;
        st_nxt.tenths = st_r.tenths + 10'h001;
      end else begin
        st_nxt.tick = st_r.tick + 22'h000001;
      end
    end
    // A zero period takes the link out as a control source
    if (st_nxt.tmo == 10'h000) begin
      st_nxt.healthy = 1'b0;
    end
    st_nxt.backup = !st_nxt.healthy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.fmt <= FMT_8N;
      st_r.baud <= BAUD_9K6;
      st_r.backup <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign protocol_select = st_r.proto;
  assign port_bit_rate = st_r.baud;
  assign char_format_select = st_r.fmt;
  assign format_conflict = st_r.conflict;
  assign msg_accept = st_r.accept;
  assign write_reject = st_r.wr_rej;
  assign link_healthy = st_r.healthy;
  assign use_backup_source = st_r.backup;
  assign loss_warning = st_r.warn;
  assign loss_trip = st_r.trip;
  assign link_speed_ref_a = st_r.ref_a;
  assign link_speed_ref_b = st_r.ref_b;
  assign link_control_word_a = st_r.cw_a;
  assign link_control_word_b = st_r.cw_b;
  assign hist_index_link = st_r.hidx_link;
  assign hist_index_keypad = st_r.hidx_kp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wr_block;
    rx_ok && rx_write && !st_r.permit |=> write_reject && $stable(st_r.cw_a);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("link write not rejected");

  property p_bcast_drop;
    rx_msg_valid && st_r.proto == PROTO_MB_RTU && rx_addr == MB_BCAST && !st_r.bcast
      |-> !rx_ok;
  endproperty
  a_bcast_drop: assert property (p_bcast_drop) else $error("broadcast not dropped");

  property p_trib_bcast;
    rx_msg_valid && !tx_busy && !st_r.conflict && st_r.proto == PROTO_TRIB &&
      rx_addr == TRIB_BCAST && st_r.bcast |=> msg_accept;
  endproperty
  a_trib_bcast: assert property (p_trib_bcast) else $error("broadcast 15 lost");

  property p_d2d_rate;
    protocol_select == PROTO_D2D |-> port_bit_rate == BAUD_19K2;
  endproperty
  a_d2d_rate: assert property (p_d2d_rate) else $error("d2d bit rate wrong");

  property p_heal;
    rx_ok && st_nxt.tmo != 10'h000 |=> link_healthy && !use_backup_source;
  endproperty
  a_heal: assert property (p_heal) else $error("link not healed");

  property p_zero_tmo;
    st_r.tmo == 10'h000 |-> !link_healthy && use_backup_source;
  endproperty
  a_zero_tmo: assert property (p_zero_tmo) else $error("zero timeout left link live");

  property p_trip;
    tmo_evt && st_r.act == ACT_TRIP |=> loss_trip && !link_healthy &&
      st_r.tmo_cnt != $past(st_r.tmo_cnt) || st_r.tmo_cnt == CNT_MAX;
  endproperty
  a_trip: assert property (p_trip) else $error("timeout trip missing");

  property p_crc_sat;
    crc_ev |=> st_r.crc_cnt == ($past(st_r.crc_cnt) == CNT_MAX ? CNT_MAX :
      $past(st_r.crc_cnt) + 14'h0001);
  endproperty
  a_crc_sat: assert property (p_crc_sat) else $error("crc count wrong");

  property p_half_duplex;
    tx_busy |-> !rx_ok ##1 !msg_accept;
  endproperty
  a_half_duplex: assert property (p_half_duplex) else $error("rx taken while tx");

  property p_loss_words;
    tmo_evt && st_r.pol |=> link_control_word_a == $past(st_r.dcw_a) &&
      link_control_word_b == $past(st_r.dcw_b);
  endproperty
  a_loss_words: assert property (p_loss_words) else $error("loss defaults not loaded");

  property p_warn;
    tmo_evt && st_r.act == ACT_WARN |=> loss_warning && !loss_trip;
  endproperty
  a_warn: assert property (p_warn) else $error("timeout warning missing");

  property p_cnt_range;
    st_r.crc_cnt <= CNT_MAX && st_r.tmo_cnt <= CNT_MAX;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count beyond range");

  property p_fail_backup;
    tmo_evt |=> use_backup_source && !link_healthy;
  endproperty
  a_fail_backup: assert property (p_fail_backup) else $error("backup not selected");

  property p_own_station;
    rx_msg_valid && !tx_busy && !st_r.conflict && st_r.proto == PROTO_MB_ASCII &&
      rx_addr == st_r.station && st_r.station != MB_BCAST |=> msg_accept;
  endproperty
  a_own_station: assert property (p_own_station) else $error("own station lost");

  property p_sel_write;
    rx_ok && rx_write && st_r.permit && rx_param_sel == SEL_CW_B |=>
      link_control_word_b == $past(rx_param_data);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("control word not written");

  property p_hidx_range;
    hist_index_link <= HIDX_MAX && hist_index_keypad <= HIDX_MAX;
  endproperty
  a_hidx_range: assert property (p_hidx_range) else $error("history index range");

  c_timeout: cover property (tmo_evt);
  c_reject: cover property (write_reject);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_loss_default: cover property (tmo_evt && st_r.pol);

endmodule // sls_top

//--- bench/sls_link_model.sv
// Remote master model driving the link receiver events
`timescale 1ns/10ps
module sls_link_model (
  // Clock
  input wire logic clk,
  // Receiver events
  output logic rx_msg_valid,
  output logic [7:0] rx_addr,
  output logic rx_crc_err,
  output logic rx_write,
  output logic [2:0] rx_param_sel,
  output logic [15:0] rx_param_data,
  output logic tx_busy
);
  initial begin
    rx_msg_valid = 1'b0;
    rx_crc_err = 1'b0;
    rx_write = 1'b0;
    rx_addr = 8'hFF;
    rx_param_sel = 3'h7;
    rx_param_data = 16'hFFFF;
    tx_busy = 1'b0;
  end
  // Caller picks the station per protocol; idle lines show the inverse of the last frame
  task automatic send(input logic bz, input logic [7:0] a, input logic [2:0] s,
                      input logic [15:0] v);
    @(posedge clk);
    rx_msg_valid <= 1'b1;
    rx_write <= 1'b1;
    rx_addr <= a;
    rx_param_sel <= s;
    rx_param_data <= v;
    tx_busy <= bz;
    @(posedge clk);
    rx_msg_valid <= 1'b0;
    rx_write <= 1'b0;
    rx_addr <= ~a;
    rx_param_sel <= ~s;
    rx_param_data <= ~v;
    tx_busy <= 1'b0;
  endtask
  task automatic crc_fail();
    @(posedge clk);
    rx_crc_err <= 1'b1;
    @(posedge clk);
    rx_crc_err <= 1'b0;
  endtask
endmodule // sls_link_model

//--- bench/tb.sv
// Self-checking testbench for the serial link supervisor
`timescale 1ns/10ps
module tb;
  import sls_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rx_addr;
  logic [31:0] pwdata, prdata;
  logic rx_msg_valid, rx_crc_err, rx_write, tx_busy, fconf, acc, rej, hlth, bkp, warn, trip;
  logic [2:0] rx_param_sel, proto, baud, fmt;
  logic [15:0] rx_param_data, d, da, db;
  logic [15:0] w [4];
  logic [15:0] ew [4];
  logic [63:0] status_flags;
  logic [6:0] hl, hk;
  logic [33:0] expq [$];
  logic [33:0] e;
  logic [21:0] tbl [10];
  int err_total = 0;
  int comparisons = 0;
  sls_top #(.TICK_CYCLES(4)) u_sls_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_msg_valid(rx_msg_valid), .rx_addr(rx_addr),
    .rx_crc_err(rx_crc_err), .rx_write(rx_write), .rx_param_sel(rx_param_sel),
    .rx_param_data(rx_param_data), .tx_busy(tx_busy), .status_flags(status_flags),
    .protocol_select(proto), .port_bit_rate(baud), .char_format_select(fmt),
    .format_conflict(fconf), .msg_accept(acc), .write_reject(rej), .link_healthy(hlth),
    .use_backup_source(bkp), .loss_warning(warn), .loss_trip(trip),
    .link_speed_ref_a(w[0]), .link_speed_ref_b(w[1]), .link_control_word_a(w[2]),
    .link_control_word_b(w[3]), .hist_index_link(hl), .hist_index_keypad(hk));
  sls_link_model u_sls_link_model (.clk(pclk), .rx_msg_valid(rx_msg_valid),
    .rx_addr(rx_addr), .rx_crc_err(rx_crc_err), .rx_write(rx_write),
    .rx_param_sel(rx_param_sel), .rx_param_data(rx_param_data), .tx_busy(tx_busy));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Request held until pready is sampled high at a rising edge, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    expq.push_back({wr, er, exp});
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk("pready timeout", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask
  task automatic frame(input logic bz, input logic [7:0] a, input logic [2:0] s,
                       input logic [15:0] v);
    u_sls_link_model.send(bz, a, s, v);
    @(negedge pclk);
  endtask
  function automatic logic [31:0] cf(logic bc, logic [2:0] pr, logic [2:0] fm,
                                     logic [1:0] ac, logic pl);
    return {21'h0, pl, ac, fm, pr, bc, 1'b1};
  endfunction
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        chk("unexpected pready", 32'h1, 32'h0);
      end else begin
        e = expq.pop_front();
        chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        if (!e[33]) begin
          chk("prdata", prdata, e[31:0]);
        end
      end
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    status_flags = 64'h0;
    ew = '{16'h0, 16'h0, 16'h0, 16'h0};
    tbl = '{{1'b0, PROTO_MB_RTU, 1'b0, 8'h05, 8'h05, 1'b1},
            {1'b0, PROTO_MB_RTU, 1'b0, 8'h05, MB_BCAST, 1'b0},
            {1'b0, PROTO_MB_RTU, 1'b1, 8'h05, MB_BCAST, 1'b1},
            {1'b0, PROTO_MB_RTU, 1'b1, 8'h05, 8'h06, 1'b0},
            {1'b0, PROTO_TRIB, 1'b1, TRIB_ADDR_MAX, TRIB_BCAST, 1'b1},
            {1'b0, PROTO_TRIB, 1'b0, TRIB_ADDR_MAX, TRIB_BCAST, 1'b0},
            {1'b0, PROTO_TRIB, 1'b1, TRIB_ADDR_MAX, TRIB_ADDR_MAX, 1'b1},
            {1'b1, PROTO_MB_RTU, 1'b0, 8'h05, 8'h05, 1'b0},
            {1'b0, PROTO_NONE, 1'b1, 8'h05, 8'h05, 1'b0},
            {1'b0, PROTO_MB_ASCII, 1'b0, 8'hFF, 8'hFF, 1'b1}};
    void'($urandom(32'h6561));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_CTRL, 0, 32'h20, 0);
    apb(0, OFF_BITRATE, 0, 32'h3, 0);
    apb(0, OFF_STATUS, 0, 32'h4, 0);
    apb(0, 8'h3C, 0, 0, 1);
    apb(0, OFF_CRCCNT, 0, 0, 0);
    $display("test reset done");
    apb(1, OFF_CTRL, {21'h0, 3'h0, FMT_8N, PROTO_MB_RTU, 2'h0}, 0, 0);
    apb(1, OFF_STATION, 5, 0, 0);
    frame(0, 8'h05, SEL_CW_A, 16'hA5A5);
    chk("write_reject", {31'h0, rej}, 32'h1);
    chk("cw_a kept", {16'h0, w[2]}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      apb(1, OFF_STATION, {24'h0, tbl[i][16:9]}, 0, 0);
      apb(1, OFF_CTRL, cf(tbl[i][17], tbl[i][20:18], FMT_8N, 0, 0), 0, 0);
      d = 16'($urandom);
      frame(tbl[i][21], tbl[i][8:1], 3'(i % 4), d);
      if (tbl[i][0]) ew[i % 4] = d;
      chk("msg_accept", {31'h0, acc}, {31'h0, tbl[i][0]});
      for (int k = 0; k < 4; k++) chk("link word", {16'h0, w[k]}, {16'h0, ew[k]});
    end
    chk("excluded link", {31'h0, hlth}, 32'h0);
    apb(1, OFF_CTRL, cf(0, PROTO_MB_RTU, FMT_7E, 0, 0), 0, 0);
    chk("conflict", {31'h0, fconf}, 32'h1);
    chk("char format", {29'h0, fmt}, {29'h0, FMT_7E});
    frame(0, 8'h05, SEL_REF_A, 16'h1234);
    chk("conflict refuse", {31'h0, acc}, 32'h0);
    $display("test addressing done");
    apb(1, OFF_BITRATE, 7, 0, 0);
    apb(0, OFF_BITRATE, 0, {29'h0, BAUD_38K4}, 0);
    for (int p = 0; p < 6; p++) begin
      apb(1, OFF_CTRL, cf(0, 3'(p), FMT_8N, 0, 0), 0, 0);
      chk("protocol", {29'h0, proto}, 32'(p));
      chk("bit rate", {29'h0, baud}, (p >= 4) ? 32'(BAUD_19K2) : 32'(BAUD_38K4));
    end
    $display("test protocol done");
    da = 16'($urandom);
    db = 16'($urandom);
    apb(1, OFF_DEFCW, {db, da}, 0, 0);
    apb(0, OFF_DEFCW, 0, {db, da}, 0);
    apb(1, OFF_TIMEOUT, 2, 0, 0);
    for (int a = 0; a < 3; a++) begin
      apb(1, OFF_CTRL, cf(0, PROTO_D2D, FMT_8N, 2'(a), a == 2), 0, 0);
      d = 16'($urandom);
      frame(0, 8'h33, SEL_CW_A, d);
      chk("healthy", {31'h0, hlth}, 32'h1);
      repeat (30) @(negedge pclk);
      chk("unhealthy", {30'h0, hlth, bkp}, 32'h1);
      chk("loss action", {30'h0, warn, trip}, {30'h0, a == 1, a == 2});
      chk("cw_a at loss", {16'h0, w[2]}, {16'h0, (a == 2) ? da : d});
    end
    apb(1, OFF_TIMEOUT, 0, 0, 0);
    frame(0, 8'h33, SEL_CW_B, 16'h0F0F);
    repeat (30) @(negedge pclk);
    apb(0, OFF_TMOCNT, 0, 3, 0);
    $display("test timeout done");
    repeat (3) u_sls_link_model.crc_fail();
    apb(0, OFF_CRCCNT, 0, 3, 0);
    @(posedge pclk);
    status_flags <= {$urandom, $urandom};
    @(negedge pclk);
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'(OFF_SWORD0 + 4 * i), 0, {16'h0, status_flags[16 * i +: 16]}, 0);
    end
    frame(0, 8'h33, SEL_HIDX, 16'd42);
    apb(1, OFF_HIDX, 7, 0, 0);
    apb(1, OFF_HIDX, 100, 0, 0);
    apb(0, OFF_HIDX, 0, 7, 0);
    frame(0, 8'h33, 3'h7, 16'h0001);
    chk("bad selector", {31'h0, rej}, 32'h1);
    chk("hidx link", {25'h0, hl}, 32'd42);
    chk("hidx keypad", {25'h0, hk}, 32'd7);
    $display("test counters status history done");
    close_out();
  end
endmodule // tb
